/* File: src/lddc_channel.sv */
`timescale 1ns/1ps
`default_nettype none
module lddc_channel #(
   parameter int TICK_CYC = lddc_pkg::TICK_CYC
) (
   input  wire logic        CLK,
   input  wire logic        RST_N,
   input  wire logic [1:0]  THRESHOLD_STEP_BUTTONS,
   input  wire logic        MODE_BUTTON,
   input  wire logic        OSCILLATOR_BAND_BUTTON,
   input  wire logic [15:0] LOOP_DELTA,
   input  wire logic [6:0]  LOOP_KHZ,
   input  wire logic        LOOP_OPEN,
   input  wire logic        LOOP_SHORT,
   input  wire logic [3:0]  REG_ADDR,
   input  wire logic [31:0] REG_WDATA,
   input  wire logic        REG_WR,
   input  wire logic        REG_RD,
   output logic [31:0]      REG_RDATA,
   output logic             OSC_ENABLE,
   output logic [1:0]       OSC_BAND,
   output logic             RETUNE_REF,
   output logic             RELAY_OUT,
   output logic             VEHICLE_PRESENT_INDICATOR,
   output logic             LOOP_FAULT_INDICATOR,
   output logic             OUT_INDICATOR,
   output logic [4:0]       DISP_CODE
);
   //------------------------------------------------------------
   // Helpers
   //------------------------------------------------------------
   // Debounce one button on the millisecond tick
   function automatic lddc_pkg::lddc_db_s db_step(
      input lddc_pkg::lddc_db_s c, input logic raw, input logic tk);
      lddc_pkg::lddc_db_s r;
      r = c;
      if (raw == c.lvl) begin
         r.cnt = '0;
      end else if (tk) begin
         if (c.cnt == 4'(lddc_pkg::T_DB_MS - 1)) begin
            r.lvl = raw;
            r.cnt = '0;
         end else begin
            r.cnt = c.cnt + 4'h1;
         end
      end
      return r;
   endfunction

   // Threshold in 0.01 % units, doubles per level step down
   function automatic logic [16:0] thresh(input logic [3:0] s);
      return 17'h00001 << (lddc_pkg::THRESHOLD_STEP_BUTTONS_MAX - s);
   endfunction

   // Levels the change stands above the threshold, up to nine
   function automatic logic [3:0] strength(
      input logic [15:0] d, input logic [3:0] s);
      logic [3:0] k;
      k = '0;
      for (int i = 0; i < 9; i++) begin
         if ({16'h0000, d} >= (32'h1 << (9 - int'(s) + i)))
            k = 4'(i + 1);
      end
      return k;
   endfunction

   // Fixed order of the output modes
   function automatic lddc_pkg::lddc_mode_e next_mode(
      input lddc_pkg::lddc_mode_e m);
      unique case (m)
         lddc_pkg::MODE_SHORT: return lddc_pkg::MODE_LONG;
         lddc_pkg::MODE_LONG:  return lddc_pkg::MODE_PULSE;
         lddc_pkg::MODE_PULSE: return lddc_pkg::MODE_CALL;
         lddc_pkg::MODE_CALL:  return lddc_pkg::MODE_OFF;
         default:              return lddc_pkg::MODE_SHORT;
      endcase
   endfunction

   //------------------------------------------------------------
   // State
   //------------------------------------------------------------
   localparam int HOLD_W_L = lddc_pkg::HOLD_W;   // Presence width
   localparam int TICK_W_L = lddc_pkg::TICK_W;   // Prescaler width
   localparam int CF_THRESHOLD_STEP_BUTTONS  = lddc_pkg::CF_THRESHOLD_STEP_BUTTONS;  // Config fields
   localparam int CF_MODE  = lddc_pkg::CF_MODE;
   localparam int CF_BAND  = lddc_pkg::CF_BAND;
   localparam int ST_PRES  = lddc_pkg::ST_PRES;  // Status fields
   localparam int ST_FLT   = lddc_pkg::ST_FLT;
   localparam int ST_CODE  = lddc_pkg::ST_CODE;
   localparam int ST_STR   = lddc_pkg::ST_STR;
   localparam int ST_RLY   = lddc_pkg::ST_RLY;
   lddc_pkg::lddc_state_s q;        // Registered state
   lddc_pkg::lddc_state_s d;        // Next state
   logic                  tick;     // Millisecond strobe
   logic                  osc_on;   // Oscillator running
   logic                  present;  // Vehicle over loop
   logic                  flt_live; // Fault standing now
   logic                  flash;    // Flash lamp phase
   logic [3:0]            str;      // Call strength
   logic [3:0]            press;    // Debounced press events
   logic [6:0]            khz;      // Clamped loop frequency
   logic [HOLD_W_L-1:0]   lim;      // Presence limit

   //------------------------------------------------------------
   // Next state
   //------------------------------------------------------------
   // Whole channel control in one combinational pass
   always_comb begin
      d = q;
      d.retune = 1'b0;
      d.rdata  = '0;
      tick = (q.pre == TICK_W_L'(TICK_CYC - 1));
      d.pre = tick ? '0 : q.pre + 1'b1;
      // Button filters
      d.db[0] = db_step(q.db[0], THRESHOLD_STEP_BUTTONS[0], tick);
      d.db[1] = db_step(q.db[1], THRESHOLD_STEP_BUTTONS[1], tick);
      d.db[2] = db_step(q.db[2], MODE_BUTTON, tick);
      d.db[3] = db_step(q.db[3], OSCILLATOR_BAND_BUTTON, tick);
      for (int i = 0; i < 4; i++) begin
         press[i] = d.db[i].lvl & ~q.db[i].lvl;
      end
      // Loop state, all per channel
      osc_on   = (q.mode != lddc_pkg::MODE_OFF);
      flt_live = osc_on & (LOOP_OPEN | LOOP_SHORT | q.chg_wait);
      present  = osc_on & ~flt_live &
                 ({1'b0, LOOP_DELTA} >= thresh(q.threshold_step_buttons));
      str      = present ? strength(LOOP_DELTA, q.threshold_step_buttons) : 4'h0;
      khz      = (LOOP_KHZ > lddc_pkg::KHZ_MAX) ?
                 lddc_pkg::KHZ_MAX : LOOP_KHZ;
      // Fault capture; a retune cycle still shows the stale delta
      if (osc_on & LOOP_OPEN) begin
         d.last_fc = lddc_pkg::FC_OPEN;
      end else if (osc_on & LOOP_SHORT) begin
         d.last_fc = lddc_pkg::FC_SHORT;
      end else if (osc_on & ~q.chg_wait & ~q.retune &
                   (LOOP_DELTA >= lddc_pkg::CHANGE_LIM)) begin
         d.last_fc  = lddc_pkg::FC_CHANGE;
         d.chg_wait = 1'b1;
         d.rtim     = 12'(lddc_pkg::T_RETUNE_MS);
      end
      // Retune after the jump fault wait
      if (q.chg_wait & tick) begin
         if (q.rtim == 12'h001) begin
            d.chg_wait = 1'b0;
            d.retune   = 1'b1;
         end
         d.rtim = q.rtim - 12'h001;
      end
      // Flash slots, code count flashes per cycle of slots
      if (tick) begin
         if (q.sub == 9'(lddc_pkg::T_SLOT_MS - 1)) begin
            d.sub  = '0;
            d.slot = q.slot + 2'h1;
         end else begin
            d.sub = q.sub + 9'h001;
         end
      end
      flash = ({1'b0, q.slot} < {1'b0, q.last_fc}) &
              (q.sub < 9'(lddc_pkg::T_FLASH_MS));
      // Display timer
      if (q.disp != lddc_pkg::DSP_IDLE && tick) begin
         if (q.dtim == 12'h001) begin
            if (q.disp == lddc_pkg::DSP_BAND && q.bstep != 3'h4) begin
               d.bstep = q.bstep + 3'h1;
               d.dtim  = 12'(lddc_pkg::T_STEP_MS);
            end else begin
               d.disp = lddc_pkg::DSP_IDLE;
            end
         end else begin
            d.dtim = q.dtim - 12'h001;
         end
      end
      // Sensitivity buttons
      if (press[0] | press[1]) begin
         if (present | q.disp == lddc_pkg::DSP_THRESHOLD_STEP_BUTTONS) begin
            if (press[0] & q.threshold_step_buttons != lddc_pkg::THRESHOLD_STEP_BUTTONS_MAX)
               d.threshold_step_buttons = q.threshold_step_buttons + 4'h1;
            else if (press[1] & q.threshold_step_buttons != lddc_pkg::THRESHOLD_STEP_BUTTONS_MIN)
               d.threshold_step_buttons = q.threshold_step_buttons - 4'h1;
         end
         if (!present) begin
            d.disp = lddc_pkg::DSP_THRESHOLD_STEP_BUTTONS;
            d.dtim = 12'(lddc_pkg::T_THRESHOLD_STEP_BUTTONS_MS);
         end
      end
      // Mode button, first press shows, next press steps
      if (press[2]) begin
         if (q.disp == lddc_pkg::DSP_MODE)
            d.mode = next_mode(q.mode);
         d.disp = lddc_pkg::DSP_MODE;
         d.dtim = 12'(lddc_pkg::T_THRESHOLD_STEP_BUTTONS_MS);
      end
      // Band button, first press shows, next press steps
      if (press[3]) begin
         if (q.disp == lddc_pkg::DSP_BAND)
            d.band = q.band + 2'h1;
         d.disp  = lddc_pkg::DSP_BAND;
         d.bstep = 3'h0;
         d.dtim  = 12'(lddc_pkg::T_STEP_MS);
      end
      // Register write, bus wins over the panel
      if (REG_WR && REG_ADDR == lddc_pkg::ADR_CONFIG) begin
         if (REG_WDATA[CF_THRESHOLD_STEP_BUTTONS+:4] >= lddc_pkg::THRESHOLD_STEP_BUTTONS_MIN &&
             REG_WDATA[CF_THRESHOLD_STEP_BUTTONS+:4] <= lddc_pkg::THRESHOLD_STEP_BUTTONS_MAX)
            d.threshold_step_buttons = REG_WDATA[CF_THRESHOLD_STEP_BUTTONS+:4];
         unique case (REG_WDATA[CF_MODE+:5])
            lddc_pkg::MODE_SHORT, lddc_pkg::MODE_LONG,
            lddc_pkg::MODE_PULSE, lddc_pkg::MODE_CALL,
            lddc_pkg::MODE_OFF:
               d.mode = lddc_pkg::lddc_mode_e'(REG_WDATA[CF_MODE+:5]);
            default: d.mode = d.mode;
         endcase
         d.band = REG_WDATA[CF_BAND+:2];
      end
      // Register read, data in the following cycle only
      if (REG_RD) begin
         if (REG_ADDR == lddc_pkg::ADR_CONFIG) begin
            d.rdata[CF_THRESHOLD_STEP_BUTTONS+:4] = q.threshold_step_buttons;
            d.rdata[CF_MODE+:5] = q.mode;
            d.rdata[CF_BAND+:2] = q.band;
         end else if (REG_ADDR == lddc_pkg::ADR_STATUS) begin
            d.rdata[ST_PRES]   = present;
            d.rdata[ST_FLT]    = flt_live;
            d.rdata[ST_CODE+:2] = q.last_fc;
            d.rdata[ST_STR+:4] = str;
            d.rdata[ST_RLY]    = q.relay;
         end
      end
      // Presence hold limit
      lim = (q.mode == lddc_pkg::MODE_LONG) ?
            lddc_pkg::LONG_MS : lddc_pkg::SHORT_MS;
      d.pres = present;
      if (!present) begin
         d.hold = '0;
         d.held = 1'b0;
      end else if (tick & ~q.held) begin
         d.hold = q.hold + 1'b1;
         if (q.hold == lim - 1'b1)
            d.held = 1'b1;
      end
      // Pulse on each vehicle arrival
      if (present & ~q.pres) begin
         d.ptim = 7'(lddc_pkg::T_PULSE_MS);
      end else if (tick && q.ptim != 7'h00) begin
         d.ptim = q.ptim - 7'h01;
      end
      // Output relay by mode, fail-safe call on fault in short and long modes only
      unique case (q.mode)
         lddc_pkg::MODE_OFF:   d.relay = 1'b0;
         lddc_pkg::MODE_CALL:  d.relay = 1'b1;
         lddc_pkg::MODE_PULSE: d.relay = (q.ptim != 7'h00);
         default:              d.relay = flt_live |
                                         (present & ~q.held);
      endcase
      // Indicators
      d.vehicle_present_indicator  = present;
      d.loop_fault_indicator  = flash;
      d.outi = flt_live ? flash : q.relay;
      // Display code
      if (flt_live) begin
         d.dcode = lddc_pkg::DC_FAULT;
      end else begin
         unique case (q.disp)
            lddc_pkg::DSP_THRESHOLD_STEP_BUTTONS: d.dcode = {1'b0, q.threshold_step_buttons};
            lddc_pkg::DSP_MODE: begin
               unique case (q.mode)
                  lddc_pkg::MODE_SHORT: d.dcode = lddc_pkg::DC_SHORT;
                  lddc_pkg::MODE_LONG:  d.dcode = lddc_pkg::DC_LONG;
                  lddc_pkg::MODE_PULSE: d.dcode = lddc_pkg::DC_PULSE;
                  lddc_pkg::MODE_CALL:  d.dcode = lddc_pkg::DC_CALL;
                  default:              d.dcode = lddc_pkg::DC_DASH;
               endcase
            end
            lddc_pkg::DSP_BAND: begin
               unique case (q.bstep)
                  3'h0:    d.dcode = {3'h0, q.band} + 5'h01;
                  3'h2:    d.dcode = 5'(khz / 7'h0A);
                  3'h3:    d.dcode = 5'(khz % 7'h0A);
                  default: d.dcode = lddc_pkg::DC_DASH;
               endcase
            end
            default: d.dcode = {1'b0, str};
         endcase
      end
   end

   //------------------------------------------------------------
   // Registers
   //------------------------------------------------------------
   // Reset to factory settings
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         q      <= '0;
         q.threshold_step_buttons <= lddc_pkg::THRESHOLD_STEP_BUTTONS_DEF;
         q.mode <= lddc_pkg::MODE_SHORT;
         q.disp <= lddc_pkg::DSP_IDLE;
      end else begin
         q <= d;
      end
   end

   // Outputs straight from flip-flops, except OSC_ENABLE decoded from the mode register
   assign REG_RDATA                 = q.rdata;
   assign OSC_ENABLE                = (q.mode != lddc_pkg::MODE_OFF);
   assign OSC_BAND                  = q.band;
   assign RETUNE_REF                = q.retune;
   assign RELAY_OUT                 = q.relay;
   assign VEHICLE_PRESENT_INDICATOR = q.vehicle_present_indicator;
   assign LOOP_FAULT_INDICATOR      = q.loop_fault_indicator;
   assign OUT_INDICATOR             = q.outi;
   assign DISP_CODE                 = q.dcode;

   //------------------------------------------------------------
   // Checks
   //------------------------------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);
   AST_THRESHOLD_STEP_BUTTONS_RANGE: assert property (q.threshold_step_buttons >= 4'h1 && q.threshold_step_buttons <= 4'h9)
      else $error("sensitivity out of range");
   AST_THRESH: assert property (##1 VEHICLE_PRESENT_INDICATOR ==
      $past(osc_on & ~flt_live & ({1'b0, LOOP_DELTA} >= thresh(q.threshold_step_buttons))))
      else $error("presence not tied to threshold");
   AST_FIRST_SHOW: assert property ((press[0] | press[1]) && !present &&
      q.disp != lddc_pkg::DSP_THRESHOLD_STEP_BUTTONS |=> $stable(q.threshold_step_buttons) &&
      q.disp == lddc_pkg::DSP_THRESHOLD_STEP_BUTTONS && q.dtim == 12'hBB8)
      else $error("first press changed level");
   AST_STEP_UP: assert property (press[0] && !press[1] &&
      q.disp == lddc_pkg::DSP_THRESHOLD_STEP_BUTTONS && q.threshold_step_buttons < 4'h9 && !REG_WR
      |=> q.threshold_step_buttons == $past(q.threshold_step_buttons) + 4'h1)
      else $error("level did not step up");
   AST_OFF: assert property (q.mode == lddc_pkg::MODE_OFF |->
      !OSC_ENABLE ##1 !RELAY_OUT)
      else $error("off mode still active");
   AST_CALL: assert property (q.mode == lddc_pkg::MODE_CALL |=>
      RELAY_OUT) else $error("call mode output low");
   AST_GLYPH: assert property (flt_live |=> DISP_CODE == 5'h11)
      else $error("fault glyph missing");
   AST_OPEN_CODE: assert property (osc_on && LOOP_OPEN |=>
      q.last_fc == 2'h1) else $error("open code not one flash");
   AST_RETUNE: assert property ($rose(q.chg_wait) |->
      !RETUNE_REF[*8] ##1 q.chg_wait) else $error("retune came early");
   AST_BAND: assert property (press[3] && !REG_WR &&
      q.disp == lddc_pkg::DSP_BAND |=> OSC_BAND == $past(q.band) + 2'h1)
      else $error("band did not step");
endmodule
`default_nettype wire

/* File: src/lddc_pkg.sv */
`default_nettype none
package lddc_pkg;
   //------------------------------------------------------------
   // Timing
   //------------------------------------------------------------
   localparam int CLK_HZ      = 125_000_000;  // Core clock rate
   localparam int T_TICK_MS   = 1;            // Time base tick
   localparam int TICK_CYC    = CLK_HZ / 1000 * T_TICK_MS;
   localparam int TICK_W      = 17;           // Prescaler width
   localparam int T_THRESHOLD_STEP_BUTTONS_MS   = 3000;         // Level display time
   localparam int T_STEP_MS   = 1000;         // Band sequence step
   localparam int T_RETUNE_MS = 2000;         // Wait before retune
   localparam int T_PULSE_MS  = 125;          // Pulse mode width
   localparam int T_SHORT_MIN = 30;           // Short presence
   localparam int T_LONG_MIN  = 120;          // Long presence
   localparam int T_DB_MS     = 10;           // Button debounce
   localparam int T_SLOT_MS   = 500;          // One flash slot
   localparam int T_FLASH_MS  = 250;          // Lamp on in a slot
   localparam int HOLD_W      = 23;           // Presence counter
   localparam logic [HOLD_W-1:0] SHORT_MS =
      HOLD_W'(T_SHORT_MIN * 60_000);
   localparam logic [HOLD_W-1:0] LONG_MS  =
      HOLD_W'(T_LONG_MIN * 60_000);
   //------------------------------------------------------------
   // Sensitivity and loop
   //------------------------------------------------------------
   localparam logic [3:0]  THRESHOLD_STEP_BUTTONS_MIN   = 4'h1;
   localparam logic [3:0]  THRESHOLD_STEP_BUTTONS_MAX   = 4'h9;
   localparam logic [3:0]  THRESHOLD_STEP_BUTTONS_DEF   = 4'h6;
   localparam logic [15:0] CHANGE_LIM = 16'h09C4;  // 25.00 %
   localparam logic [6:0]  KHZ_MAX    = 7'h63;
   //------------------------------------------------------------
   // Fault codes equal their flash counts
   //------------------------------------------------------------
   localparam logic [1:0] FC_NONE   = 2'h0;
   localparam logic [1:0] FC_OPEN   = 2'h1;
   localparam logic [1:0] FC_SHORT  = 2'h2;
   localparam logic [1:0] FC_CHANGE = 2'h3;
   //------------------------------------------------------------
   // Display codes, digits are 00..09
   //------------------------------------------------------------
   localparam logic [4:0] DC_DASH  = 5'h10;
   localparam logic [4:0] DC_FAULT = 5'h11;
   localparam logic [4:0] DC_SHORT = 5'h12;
   localparam logic [4:0] DC_LONG  = 5'h13;
   localparam logic [4:0] DC_PULSE = 5'h14;
   localparam logic [4:0] DC_CALL  = 5'h15;
   //------------------------------------------------------------
   // Registers
   //------------------------------------------------------------
   localparam logic [3:0] ADR_CONFIG = 4'h0;
   localparam logic [3:0] ADR_STATUS = 4'h1;
   localparam int CF_THRESHOLD_STEP_BUTTONS = 0;   // [3:0]
   localparam int CF_MODE = 4;   // [8:4]
   localparam int CF_BAND = 9;   // [10:9]
   localparam int ST_PRES = 0;
   localparam int ST_FLT  = 1;
   localparam int ST_CODE = 2;   // [3:2]
   localparam int ST_STR  = 4;   // [7:4]
   localparam int ST_RLY  = 8;
   //------------------------------------------------------------
   // Types
   //------------------------------------------------------------
   typedef enum logic [4:0] {
      MODE_SHORT = 5'h01, MODE_LONG = 5'h02, MODE_PULSE = 5'h04,
      MODE_CALL  = 5'h08, MODE_OFF  = 5'h10
   } lddc_mode_e;
   typedef enum logic [3:0] {
      DSP_IDLE = 4'h1, DSP_THRESHOLD_STEP_BUTTONS = 4'h2, DSP_MODE = 4'h4,
      DSP_BAND = 4'h8
   } lddc_disp_e;
   typedef struct packed {
      logic       lvl;   // Debounced level
      logic [3:0] cnt;   // Stable time so far
   } lddc_db_s;
   typedef struct packed {
      logic [TICK_W-1:0] pre;
      lddc_db_s [3:0]    db;
      logic [3:0]        threshold_step_buttons;
      lddc_mode_e        mode;
      logic [1:0]        band;
      lddc_disp_e        disp;
      logic [11:0]       dtim;
      logic [2:0]        bstep;
      logic [1:0]        last_fc;
      logic              chg_wait;
      logic [11:0]       rtim;
      logic [1:0]        slot;
      logic [8:0]        sub;
      logic [HOLD_W-1:0] hold;
      logic              held;
      logic              pres;
      logic [6:0]        ptim;
      logic [31:0]       rdata;
      logic              retune;
      logic              relay;
      logic              vehicle_present_indicator;
      logic              loop_fault_indicator;
      logic              outi;
      logic [4:0]        dcode;
   } lddc_state_s;
endpackage
`default_nettype wire

/* File: test/lddc_front.sv */
`timescale 1ns/1ps
`default_nettype none
// Loop front end: delta against a retunable reference
module lddc_front (
   input  wire logic        CLK,
   input  wire logic        RST_N,
   input  wire logic        OSC_ENABLE,
   input  wire logic [1:0]  OSC_BAND,
   input  wire logic        RETUNE_REF,
   input  wire logic [15:0] want_delta,
   input  wire logic        want_open,
   input  wire logic        want_short,
   output logic      [15:0] LOOP_DELTA,
   output logic      [6:0]  LOOP_KHZ,
   output logic             LOOP_OPEN,
   output logic             LOOP_SHORT
);
   logic [15:0] ref_q;  // Offset taken at retune
   // Retune moves the reference to the present loop
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) ref_q <= 16'h0000;
      else if (RETUNE_REF) ref_q <= want_delta;
   end
   // A stopped oscillator measures nothing
   always_comb begin
      LOOP_DELTA = 16'h0000;
      LOOP_KHZ   = 7'h00;
      if (OSC_ENABLE) begin
         if (want_delta > ref_q) LOOP_DELTA = want_delta - ref_q;
         LOOP_KHZ = 7'h14 + 7'(OSC_BAND) * 7'h05;
      end
   end
   assign LOOP_OPEN  = want_open;
   assign LOOP_SHORT = want_short;
endmodule
`default_nettype wire

/* File: test/loop_detector_channel_control_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module loop_detector_channel_control_bench;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [3:0]  btn = 4'h0;   // Up, down, mode, band
   logic [3:0]  adr = 4'h0;
   logic [31:0] wd = 32'h0, rdat, r;
   logic        wr = 1'b0, rd = 1'b0;
   logic        osc, retune, relay, veh, loop_fault_indicator, outi, lo, ls;
   logic [1:0]  band;
   logic [4:0]  disp;
   logic [15:0] dl, w_d = 16'h0000;
   logic [6:0]  khz;
   logic        f_o = 1'b0, f_s = 1'b0;
   int          n_mismatch = 0, num_checks = 0, n, m, k;
   logic [4:0]  mds[5] = '{5'h02, 5'h04, 5'h08, 5'h10, 5'h01};
   logic [4:0]  dsp[5] = '{5'h13, 5'h14, 5'h15, 5'h10, 5'h12};
   logic [4:0]  bsq[5] = '{5'h01, 5'h10, 5'h02, 5'h00, 5'h10};
   always #4 clk = ~clk;
   lddc_channel #(.TICK_CYC(4)) i_dut (.CLK(clk), .RST_N(rst_n),
      .THRESHOLD_STEP_BUTTONS(btn[1:0]), .MODE_BUTTON(btn[2]),
      .OSCILLATOR_BAND_BUTTON(btn[3]), .LOOP_DELTA(dl), .LOOP_KHZ(khz),
      .LOOP_OPEN(lo), .LOOP_SHORT(ls), .REG_ADDR(adr), .REG_WDATA(wd),
      .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdat), .OSC_ENABLE(osc),
      .OSC_BAND(band), .RETUNE_REF(retune), .RELAY_OUT(relay),
      .VEHICLE_PRESENT_INDICATOR(veh), .LOOP_FAULT_INDICATOR(loop_fault_indicator),
      .OUT_INDICATOR(outi), .DISP_CODE(disp));
   lddc_front i_front (.CLK(clk), .RST_N(rst_n), .OSC_ENABLE(osc),
      .OSC_BAND(band), .RETUNE_REF(retune), .want_delta(w_d),
      .want_open(f_o), .want_short(f_s), .LOOP_DELTA(dl),
      .LOOP_KHZ(khz), .LOOP_OPEN(lo), .LOOP_SHORT(ls));
   function automatic logic [31:0] cfg(input logic [3:0] s,
      input logic [4:0] md, input logic [1:0] b);
      return {21'h0, b, md, s};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wrr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      adr <= a;
      wd <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rdr(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk);
      adr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdat;
   endtask
   task automatic press(input int i, input int hold);
      @(posedge clk);
      btn[i] <= 1'b1;
      repeat (hold) @(posedge clk);
      btn[i] <= 1'b0;
      repeat (60) @(posedge clk);
      #1;
   endtask
   task automatic setd(input logic [15:0] v);
      @(posedge clk);
      w_d <= v;
      repeat (6) @(posedge clk);
      #1;
   endtask
   // Count lamp flashes over one whole code period
   task automatic flashes(output int fl, output int fo);
      logic pl, po;
      fl = 0;
      fo = 0;
      pl = loop_fault_indicator;
      po = outi;
      repeat (8000) begin
         @(posedge clk);
         #1;
         if (loop_fault_indicator && !pl) fl++;
         if (outi && !po) fo++;
         pl = loop_fault_indicator;
         po = outi;
      end
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // Watchdog against a hang
   initial begin
      repeat (90000) @(posedge clk);
      n_mismatch++;
      wrap_up();
   end
   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      rdr(0, r);
      chk(r, cfg(6, 1, 0));
      chk(32'(osc), 1);
      for (k = 1; k <= 9; k++) begin
         wrr(0, cfg(4'(k), 1, 0));
         setd(16'((1 << (9 - k)) - 1));
         rdr(1, r);
         chk(r, 0);
         chk(32'(veh), 0);
         setd(16'(1 << (9 - k)));
         rdr(1, r);
         chk(r, 32'h111);
         chk(32'(veh), 1);
      end
      wrr(0, cfg(7, 1, 0));
      setd(32);
      rdr(1, r);
      chk(r, 32'h141);
      chk(32'(disp), 4);
      press(1, 60);
      rdr(1, r);
      chk(r, 32'h131);
      chk(32'(disp), 3);
      setd(0);
      r = 32'(disp);
      press(0, 20);
      chk(32'(disp), r);
      press(0, 60);
      chk(32'(disp), 6);
      press(0, 60);
      chk(32'(disp), 7);
      wrr(0, cfg(4'hA, 5'h03, 0));
      rdr(0, r);
      chk(r, cfg(7, 1, 0));
      wrr(0, cfg(9, 1, 0));
      press(0, 60);
      press(0, 60);
      chk(32'(disp), 9);
      press(2, 60);
      chk(32'(disp), 32'(lddc_pkg::DC_SHORT));
      for (k = 0; k < 5; k++) begin
         press(2, 60);
         chk(32'(disp), 32'(dsp[k]));
         rdr(0, r);
         chk(32'(r[8:4]), 32'(mds[k]));
      end
      wrr(0, cfg(6, 8, 0));
      setd(0);
      chk(32'(relay), 1);
      wrr(0, cfg(6, 5'h10, 0));
      setd(100);
      chk(32'({osc, relay}), 0);
      wrr(0, cfg(6, 4, 0));
      setd(0);
      @(posedge clk);
      w_d <= 16'd100;
      n = 0;
      for (k = 0; k < 1000; k++) begin
         @(posedge clk);
         #1;
         if (relay) n++;
      end
      chk(32'(n >= 490 && n <= 510), 1);
      wrr(0, cfg(6, 1, 0));
      setd(0);
      press(3, 60);
      repeat (1900) @(posedge clk);
      for (k = 0; k < 5; k++) begin
         #1 chk(32'(disp), 32'(bsq[k]));
         repeat (4000) @(posedge clk);
      end
      press(3, 60);
      press(3, 60);
      chk(32'(band), 1);
      for (k = 1; k <= 2; k++) begin
         @(posedge clk);
         f_o <= (k == 1);
         f_s <= (k == 2);
         repeat (50) @(posedge clk);
         #1 chk(32'(disp), 32'(lddc_pkg::DC_FAULT));
         rdr(1, r);
         chk(r & 32'h0000000E, 32'(2 + 4 * k));
         flashes(n, m);
         chk(32'(n * 4 + m), 32'(k * 5));
         @(posedge clk);
         f_o <= 1'b0;
         f_s <= 1'b0;
         repeat (50) @(posedge clk);
         rdr(1, r);
         chk(r & 32'h0000000E, 32'(4 * k));
         chk(32'(disp != lddc_pkg::DC_FAULT), 1);
      end
      @(posedge clk);
      w_d <= 16'd2600;
      n = 0;
      while (!retune && n < 9000) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk(32'(n >= 7990 && n <= 8010), 1);
      repeat (10) @(posedge clk);
      rdr(1, r);
      chk(r & 32'h0000000E, 32'h0000000C);
      chk(32'(disp != lddc_pkg::DC_FAULT), 1);
      flashes(n, m);
      chk(32'(n), 3);
      wrap_up();
   end
endmodule
`default_nettype wire
